// ===== data_mem_pkg.sv
// shared constants and carrier types for the internal data memory map
package data_mem_pkg;
	localparam logic [7:0] LOWER_TOP = 8'h7f;
	localparam logic [7:0] BANK_TOP = 8'h1f;
	localparam logic [7:0] BIT_AREA_BASE = 8'h20;
	localparam logic [7:0] SFR_STACK_POINTER = 8'h81;
	localparam logic [7:0] SFR_PROGRAM_STATUS_WORD = 8'hd0;
	localparam logic [7:0] STACK_POINTER_RESET = 8'h07;
	localparam logic [7:0] PROGRAM_STATUS_WORD_RESET = 8'h00;
	localparam int BANK_SELECT_LOW_POS = 3;
	localparam int BANK_SELECT_HIGH_POS = 4;
	localparam int EXT_DATA_DEPTH = 512;
	localparam int EXT_DATA_ADDR_WIDTH = 9;

	typedef enum logic [2:0] {
		MODE_DIRECT = 3'b000,
		MODE_INDIRECT = 3'b001,
		MODE_REG = 3'b010,
		MODE_BIT = 3'b011,
		MODE_STACK = 3'b100
	} access_mode_type;

	typedef enum logic [1:0] {
		STACK_NONE = 2'b00,
		STACK_PUSH = 2'b01,
		STACK_POP = 2'b10
	} stack_op_type;

	// one operand access from the core
	typedef struct packed {
		logic valid;
		logic write;
		access_mode_type mode;
		stack_op_type stack_op;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mem_req_type;

	// external data space access from the core
	typedef struct packed {
		logic valid;
		logic write;
		logic [EXT_DATA_ADDR_WIDTH-1:0] addr;
		logic [7:0] wdata;
	} external_data_space_req_type;
endpackage

// ===== iram_store.sv
// byte-wide storage array with one synchronous write and one read port
`timescale 1ns/100ps
module iram_store #(
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic mclk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:DEPTH-1];

	// contents are not reset, matching real ram
	always_ff @(posedge mclk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		rdata_o <= mem[raddr_i];
	end
endmodule

// ===== internal_data_memory_map.sv
// address decode, bank, bit, stack and sfr handling of the internal data memory
`timescale 1ns/100ps
// Summary of operation
// [RULE1] 256 bytes of internal ram at data addresses 0x00 to 0xff.
// [RULE2] lower 128 bytes reachable by both direct and indirect addressing.
// [RULE3] 0x00..0x1f hold four banks of eight byte registers.
// [RULE4] one active bank, chosen by status word bits 3 and 4.
// [RULE5] indirect modes take the pointer from index register zero or one.
// [RULE6] bytes 0x20..0x2f give bits 0x00..0x7f; byte 0x20+k bit n is 8k+n.
// [RULE7] bit versus byte access chosen only by the operand type.
// [RULE8] upper 128 bytes indirect only, storage separate from the sfrs.
// [RULE9] above 0x7f, direct selects sfr space, indirect selects upper ram.
// [RULE10] pointer marks last used slot; push writes pointer plus one, then increments.
// [RULE11] reset loads the stack pointer with 0x07.
// [RULE12] the stack may sit anywhere in the 256 bytes, up to 256 deep.
// [RULE13] stack pointer is the sfr at 0x81.
// [RULE14] sfrs at 0x80..0xff direct; those ending 0x0 or 0x8 also bit addressable. Here bit writes change only the status word; other sfrs get no write strobe.
// [RULE15] software must not touch unoccupied sfr addresses; result is indeterminate.
// [RULE16] 512 bytes of on-chip ram in the external data space.
// [RULE17] bank number is high select bit then low; register n at bank*8+n.
// [RULE18] bit addresses 0x80..0xff: upper five bits pick sfr, lower three the bit.
// [RULE19] stack pointer is eight bits and wraps modulo 256.
module internal_data_memory_map (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input data_mem_pkg::mem_req_type req_i,
	input wire logic [2:0] reg_index_i,
	input wire logic index_sel_i,
	output logic [7:0] rdata_o,
	output logic rbit_o,
	output logic rvalid_o,
	output logic ext_sfr_sel_o,
	output logic ext_sfr_we_o,
	output logic [7:0] ext_sfr_addr_o,
	output logic [7:0] ext_sfr_wdata_o,
	input wire logic [7:0] ext_sfr_rdata_i,
	input data_mem_pkg::external_data_space_req_type xreq_i,
	output logic [7:0] xrdata_o,
	output logic xrvalid_o,
	output logic [7:0] stack_pointer_o,
	output logic [1:0] active_bank_o
);
	logic [7:0] stack_pointer;
	logic [7:0] program_status_word;
	logic [1:0] bank;
	logic [7:0] ram_addr;
	logic [7:0] ram_rdata;
	logic [7:0] ptr_value;
	logic ram_we;
	logic [7:0] ram_wdata;
	logic ptr_phase;
	logic is_sfr;
	logic is_bit;
	logic [7:0] byte_addr;
	logic [2:0] bit_pos;
	logic [2:0] rd_bit_pos;
	logic rd_is_bit;
	logic rd_from_sfr;
	logic [7:0] rd_sfr_value;
	logic rd_pending;
	logic [7:0] next_stack_pointer;
	logic [7:0] sfr_rdata;
	logic bit_wr_pending;
	logic [7:0] bit_wr_addr;
	logic [2:0] bit_wr_pos;
	logic bit_wr_value;
	logic bit_wr_sfr;

	// byte address holding a bit: low area or a bit-capable sfr
	function automatic logic [7:0] bit_to_byte(input logic [7:0] bit_addr);
		if (bit_addr[7]) begin
			bit_to_byte = {bit_addr[7:3], 3'b000}; // see [RULE18]
		end else begin
			bit_to_byte = 8'(data_mem_pkg::BIT_AREA_BASE + {4'h0, bit_addr[6:3]}); // see [RULE6]
		end
	endfunction

	// address of register n in the active bank
	function automatic logic [7:0] bank_reg_addr(input logic [1:0] b, input logic [2:0] n);
		bank_reg_addr = {3'b000, b, n}; // see [RULE17] [RULE3]
	endfunction

	// see [RULE4] [RULE17]
	assign bank = {program_status_word[data_mem_pkg::BANK_SELECT_HIGH_POS],
		program_status_word[data_mem_pkg::BANK_SELECT_LOW_POS]};
	assign active_bank_o = bank;
	assign stack_pointer_o = stack_pointer;

	// the index register read in the first cycle stands on the ram output in the second,
	// so the pointer is taken straight from it; a further register would lag a cycle
	assign ptr_value = ram_rdata; // see [RULE5]

	// bit or byte is chosen only by the operand type carried in the request
	assign is_bit = (req_i.mode == data_mem_pkg::MODE_BIT); // see [RULE7]
	assign bit_pos = req_i.addr[2:0];

	always_comb begin
		byte_addr = req_i.addr;
		is_sfr = 1'b0;
		unique case (req_i.mode)
			data_mem_pkg::MODE_DIRECT: begin
				// direct above 0x7f reaches sfr space, below reaches ram
				is_sfr = req_i.addr > data_mem_pkg::LOWER_TOP; // see [RULE9] [RULE14] [RULE2]
			end
			data_mem_pkg::MODE_INDIRECT: begin
				// indirect always reaches ram, including the upper 128 bytes
				byte_addr = ptr_value; // see [RULE8] [RULE9] [RULE2]
			end
			data_mem_pkg::MODE_REG: begin
				byte_addr = bank_reg_addr(bank, reg_index_i); // see [RULE3]
			end
			data_mem_pkg::MODE_BIT: begin
				byte_addr = bit_to_byte(req_i.addr);
				is_sfr = req_i.addr[7]; // see [RULE14]
			end
			data_mem_pkg::MODE_STACK: begin
				// push goes to pointer plus one, pop reads the current top
				byte_addr = (req_i.stack_op == data_mem_pkg::STACK_PUSH) ?
					8'(stack_pointer + 8'h01) : stack_pointer; // see [RULE10] [RULE12]
			end
			default: begin
				byte_addr = req_i.addr;
			end
		endcase
	end

	// indirect needs the index register first; the core holds the request for it
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ptr_phase <= 1'b0;
		end else begin
			ptr_phase <= req_i.valid && (req_i.mode == data_mem_pkg::MODE_INDIRECT) && !ptr_phase;
		end
	end

	// a bit write is a read-modify-write over two cycles; ram port is shared
	always_comb begin
		ram_we = 1'b0;
		ram_wdata = req_i.wdata;
		ram_addr = byte_addr;
		if (bit_wr_pending && !bit_wr_sfr) begin
			ram_we = 1'b1;
			ram_addr = bit_wr_addr;
			ram_wdata = ram_rdata;
			ram_wdata[bit_wr_pos] = bit_wr_value;
		end else if (req_i.valid && req_i.mode == data_mem_pkg::MODE_INDIRECT && !ptr_phase) begin
			ram_addr = bank_reg_addr(bank, {2'b00, index_sel_i}); // see [RULE5]
		end else if (req_i.valid && req_i.write && !is_sfr && !is_bit) begin
			ram_we = (req_i.mode != data_mem_pkg::MODE_STACK) ||
				(req_i.stack_op == data_mem_pkg::STACK_PUSH);
		end
	end

	iram_store #(
		.DEPTH(256),
		.AW(8)
	) u_iram (
		.mclk_i(mclk_i),
		.we_i(ram_we),
		.waddr_i(ram_addr),
		.wdata_i(ram_wdata),
		.raddr_i(ram_addr),
		.rdata_o(ram_rdata)
	); // see [RULE1] [RULE8]

	// the stack pointer steps on the same clock edge as the push data lands
	always_comb begin
		next_stack_pointer = stack_pointer;
		if (req_i.valid && req_i.write && req_i.mode == data_mem_pkg::MODE_DIRECT &&
			req_i.addr == data_mem_pkg::SFR_STACK_POINTER) begin
			next_stack_pointer = req_i.wdata; // see [RULE13]
		end else if (req_i.valid && req_i.mode == data_mem_pkg::MODE_STACK) begin
			if (req_i.stack_op == data_mem_pkg::STACK_PUSH) begin
				next_stack_pointer = 8'(stack_pointer + 8'h01); // see [RULE10] [RULE19]
			end else if (req_i.stack_op == data_mem_pkg::STACK_POP) begin
				next_stack_pointer = 8'(stack_pointer - 8'h01); // see [RULE19]
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stack_pointer <= data_mem_pkg::STACK_POINTER_RESET; // see [RULE11]
		end else if (bit_wr_pending && bit_wr_sfr &&
			bit_wr_addr == data_mem_pkg::SFR_STACK_POINTER) begin
			stack_pointer <= stack_pointer;
		end else begin
			stack_pointer <= next_stack_pointer;
		end
	end

	// status word: byte writes and bit writes to its bit-capable address
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			program_status_word <= data_mem_pkg::PROGRAM_STATUS_WORD_RESET;
		end else if (bit_wr_pending && bit_wr_sfr &&
			bit_wr_addr == data_mem_pkg::SFR_PROGRAM_STATUS_WORD) begin
			program_status_word[bit_wr_pos] <= bit_wr_value; // see [RULE14]
		end else if (req_i.valid && req_i.write && req_i.mode == data_mem_pkg::MODE_DIRECT &&
			req_i.addr == data_mem_pkg::SFR_PROGRAM_STATUS_WORD) begin
			program_status_word <= req_i.wdata; // see [RULE4]
		end
	end

	// sfrs not held here are handed to the peripherals; unused addresses give
	// whatever the outside returns, which is undefined by design
	always_comb begin
		unique case (byte_addr)
			data_mem_pkg::SFR_STACK_POINTER: sfr_rdata = stack_pointer;
			data_mem_pkg::SFR_PROGRAM_STATUS_WORD: sfr_rdata = program_status_word;
			default: sfr_rdata = ext_sfr_rdata_i; // see [RULE15]
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_sfr_sel_o <= 1'b0;
			ext_sfr_we_o <= 1'b0;
			ext_sfr_addr_o <= 8'h00;
			ext_sfr_wdata_o <= 8'h00;
		end else begin
			ext_sfr_sel_o <= req_i.valid && is_sfr;
			ext_sfr_we_o <= req_i.valid && is_sfr && req_i.write && !is_bit;
			ext_sfr_addr_o <= byte_addr;
			ext_sfr_wdata_o <= req_i.wdata;
		end
	end

	// bit write: latch target, merge into the byte read back next cycle
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_wr_pending <= 1'b0;
			bit_wr_addr <= 8'h00;
			bit_wr_pos <= 3'h0;
			bit_wr_value <= 1'b0;
			bit_wr_sfr <= 1'b0;
		end else begin
			bit_wr_pending <= req_i.valid && req_i.write && is_bit && !bit_wr_pending;
			bit_wr_addr <= byte_addr;
			bit_wr_pos <= bit_pos; // see [RULE6]
			bit_wr_value <= req_i.wdata[0];
			bit_wr_sfr <= is_sfr;
		end
	end

	// read answer two cycles after the request
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_pending <= 1'b0;
			rd_is_bit <= 1'b0;
			rd_bit_pos <= 3'h0;
			rd_from_sfr <= 1'b0;
			rd_sfr_value <= 8'h00;
		end else begin
			rd_pending <= req_i.valid && !req_i.write &&
				!(req_i.mode == data_mem_pkg::MODE_INDIRECT && !ptr_phase);
			rd_is_bit <= is_bit;
			rd_bit_pos <= bit_pos;
			rd_from_sfr <= is_sfr;
			rd_sfr_value <= sfr_rdata;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 8'h00;
			rbit_o <= 1'b0;
		end else if (rd_pending) begin
			rdata_o <= rd_from_sfr ? rd_sfr_value : ram_rdata;
			rbit_o <= rd_from_sfr ? rd_sfr_value[rd_bit_pos] : ram_rdata[rd_bit_pos];
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= rd_pending;
		end
	end

	// 512 bytes of on-chip ram in the external data space
	logic [7:0] xram_rdata;
	logic xrd_pending;

	iram_store #(
		.DEPTH(data_mem_pkg::EXT_DATA_DEPTH),
		.AW(data_mem_pkg::EXT_DATA_ADDR_WIDTH)
	) u_xram (
		.mclk_i(mclk_i),
		.we_i(xreq_i.valid && xreq_i.write),
		.waddr_i(xreq_i.addr),
		.wdata_i(xreq_i.wdata),
		.raddr_i(xreq_i.addr),
		.rdata_o(xram_rdata)
	); // see [RULE16]

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			xrd_pending <= 1'b0;
		end else begin
			xrd_pending <= xreq_i.valid && !xreq_i.write;
		end
	end

	assign xrdata_o = xram_rdata;
	assign xrvalid_o = xrd_pending;

	sequence push_req_s;
		req_i.valid && req_i.mode == data_mem_pkg::MODE_STACK &&
			req_i.stack_op == data_mem_pkg::STACK_PUSH;
	endsequence

	AST_PUSH_STEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see [RULE10]
		push_req_s |=> stack_pointer == 8'($past(stack_pointer) + 8'h01))
		else $error("push did not step the stack pointer by one");

	AST_PUSH_ADDR: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see [RULE10]
		push_req_s |-> ram_we && ram_addr == 8'(stack_pointer + 8'h01))
		else $error("push not written at pointer plus one");

	AST_POP_STEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see [RULE19]
		req_i.valid && req_i.mode == data_mem_pkg::MODE_STACK &&
		req_i.stack_op == data_mem_pkg::STACK_POP |=>
		stack_pointer == 8'($past(stack_pointer) - 8'h01))
		else $error("pop did not step the stack pointer down");

	AST_BANK_ADDR: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see [RULE17]
		req_i.mode == data_mem_pkg::MODE_REG |->
		byte_addr == {3'b000, program_status_word[4], program_status_word[3], reg_index_i})
		else $error("bank register address wrong");

	AST_DIRECT_UPPER: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see [RULE9]
		req_i.valid && req_i.mode == data_mem_pkg::MODE_DIRECT && req_i.addr[7] |=> ext_sfr_sel_o)
		else $error("direct upper access missed sfr space");

	AST_INDIRECT_RAM: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see [RULE8]
		req_i.valid && req_i.mode == data_mem_pkg::MODE_INDIRECT |=> !ext_sfr_sel_o)
		else $error("indirect access reached sfr space");

	AST_BIT_LOW: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see [RULE6]
		req_i.mode == data_mem_pkg::MODE_BIT && !req_i.addr[7] |->
		byte_addr == 8'(data_mem_pkg::BIT_AREA_BASE + {4'h0, req_i.addr[6:3]}) && !is_sfr)
		else $error("low bit address mapped wrong");

	AST_BIT_SFR: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see [RULE18]
		req_i.mode == data_mem_pkg::MODE_BIT && req_i.addr[7] |->
		byte_addr[2:0] == 3'h0 && byte_addr[7:3] == req_i.addr[7:3] && is_sfr)
		else $error("sfr bit address mapped wrong");
endmodule

// ===== sfr_model.sv
// peripheral special function register responder used by the bench
`timescale 1ns/100ps
module sfr_model (
	input wire logic mclk_i,
	input wire logic sel_i,
	input wire logic we_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] raddr_i,
	output logic [7:0] rdata_o
);
	logic [7:0] regs [128];
	initial begin
		for (int i = 0; i < 128; i++) regs[i] = 8'h5a ^ 8'(i);
	end
	// the byte arrives on the registered strobe, a cycle after the request
	always @(posedge mclk_i) begin
		if (sel_i && we_i && addr_i[7]) regs[addr_i[6:0]] <= wdata_i;
	end
	// combinational answer, since the block samples it in the request cycle
	assign rdata_o = raddr_i[7] ? regs[raddr_i[6:0]] : ~raddr_i;
endmodule

// ===== internal_data_memory_map_test.sv
// self-checking bench for the internal data memory map
`timescale 1ns/100ps
module internal_data_memory_map_test;
	localparam data_mem_pkg::access_mode_type DIR = data_mem_pkg::MODE_DIRECT;
	localparam data_mem_pkg::access_mode_type IND = data_mem_pkg::MODE_INDIRECT;
	localparam data_mem_pkg::access_mode_type REG = data_mem_pkg::MODE_REG;
	localparam data_mem_pkg::access_mode_type BIT = data_mem_pkg::MODE_BIT;
	localparam data_mem_pkg::access_mode_type STK = data_mem_pkg::MODE_STACK;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	data_mem_pkg::mem_req_type req = '0;
	data_mem_pkg::external_data_space_req_type xreq = '0;
	logic [2:0] reg_index = 3'h0;
	logic index_sel = 1'b0;
	logic [7:0] rdata, sfr_addr, sfr_wdata, sfr_rdata, xrdata, stack_ptr, got, s_addr, s_wdata;
	logic rbit, rvalid, sfr_sel, sfr_we, xrvalid, gotbit, s_sel, s_we;
	logic [1:0] bank;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;
	always #4 mclk_i = ~mclk_i;
	internal_data_memory_map dut (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.req_i(req),
		.reg_index_i(reg_index),
		.index_sel_i(index_sel),
		.rdata_o(rdata),
		.rbit_o(rbit),
		.rvalid_o(rvalid),
		.ext_sfr_sel_o(sfr_sel),
		.ext_sfr_we_o(sfr_we),
		.ext_sfr_addr_o(sfr_addr),
		.ext_sfr_wdata_o(sfr_wdata),
		.ext_sfr_rdata_i(sfr_rdata),
		.xreq_i(xreq),
		.xrdata_o(xrdata),
		.xrvalid_o(xrvalid),
		.stack_pointer_o(stack_ptr),
		.active_bank_o(bank)
	);
	sfr_model peripherals (
		.mclk_i(mclk_i),
		.sel_i(sfr_sel),
		.we_i(sfr_we),
		.addr_i(sfr_addr),
		.wdata_i(sfr_wdata),
		.raddr_i(req.mode == BIT ? {req.addr[7:3], 3'h0} : req.addr),
		.rdata_o(sfr_rdata)
	);
	task automatic close_out;
		if (fail_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			close_out();
		end
	end
	task automatic chk8(input logic [7:0] act, input logic [7:0] exp);
		n_tests++;
		if (act !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, act, exp);
		end
	endtask
	task automatic chk1(input logic act, input logic exp);
		chk8({7'h0, act}, {7'h0, exp});
	endtask
	task automatic tick;
		@(posedge mclk_i);
		#1;
	endtask
	// writes are followed by an idle cycle so a bit write can finish its merge
	task automatic acc(input data_mem_pkg::access_mode_type m, input logic w,
			input logic [7:0] a, input logic [7:0] d,
			input data_mem_pkg::stack_op_type s = data_mem_pkg::STACK_NONE);
		req = '{valid: 1'b1, write: w, mode: m, stack_op: s, addr: a, wdata: d};
		tick();
		{s_sel, s_we, s_addr, s_wdata} = {sfr_sel, sfr_we, sfr_addr, sfr_wdata};
		if (m == IND) tick();
		req.valid = 1'b0;
		if (w) begin
			tick();
		end else begin
			for (int i = 0; i < 6 && rvalid !== 1'b1; i++) tick();
			got = rdata;
			gotbit = rbit;
			chk1(rvalid, 1'b1);
		end
	endtask
	task automatic xacc(input logic w, input logic [8:0] a, input logic [7:0] d);
		xreq = '{valid: 1'b1, write: w, addr: a, wdata: d};
		tick();
		xreq.valid = 1'b0;
		for (int i = 0; i < 3 && xrvalid !== 1'b1; i++) tick();
		got = xrdata;
		if (!w) chk1(xrvalid, 1'b1);
	endtask
	task automatic t_reset;
		chk8(stack_ptr, 8'h07);
		chk8({6'h0, bank}, 8'h00);
		acc(DIR, 1'b0, 8'h81, 8'h00);
		chk8(got, 8'h07);
	endtask
	task automatic t_spaces;
		acc(DIR, 1'b1, 8'h30, 8'h5a);
		acc(DIR, 1'b1, 8'h00, 8'h30);
		acc(DIR, 1'b1, 8'h01, 8'h90);
		index_sel = 1'b0;
		acc(IND, 1'b0, 8'h00, 8'h00);
		chk8(got, 8'h5a);
		index_sel = 1'b1;
		acc(IND, 1'b1, 8'h00, 8'ha5);
		acc(DIR, 1'b1, 8'h90, 8'h3c); // occupied latch address only
		chk8({6'h0, s_sel, s_we}, 8'h03);
		chk8(s_addr, 8'h90);
		chk8(s_wdata, 8'h3c);
		acc(IND, 1'b0, 8'h00, 8'h00);
		chk8(got, 8'ha5);
		acc(DIR, 1'b0, 8'h90, 8'h00);
		chk8(got, 8'h3c);
		acc(DIR, 1'b1, 8'h01, 8'hff);
		acc(IND, 1'b1, 8'h00, 8'h77);
		acc(IND, 1'b0, 8'h00, 8'h00);
		chk8(got, 8'h77);
	endtask
	task automatic t_banks;
		reg_index = 3'h7;
		for (int b = 0; b < 4; b++) begin
			acc(DIR, 1'b1, 8'hd0, 8'(b << 3));
			chk8({6'h0, bank}, 8'(b));
			acc(REG, 1'b1, 8'h00, 8'h40 + 8'(b));
			acc(DIR, 1'b0, 8'(b * 8 + 7), 8'h00);
			chk8(got, 8'h40 + 8'(b));
		end
		acc(DIR, 1'b1, 8'hd0, 8'h00);
	endtask
	task automatic t_bits;
		acc(DIR, 1'b1, 8'h22, 8'h00);
		acc(DIR, 1'b1, 8'h2f, 8'h00);
		acc(BIT, 1'b1, 8'h13, 8'hff);
		acc(BIT, 1'b1, 8'h7f, 8'hff);
		acc(DIR, 1'b0, 8'h22, 8'h00);
		chk8(got, 8'h08);
		acc(DIR, 1'b0, 8'h2f, 8'h00);
		chk8(got, 8'h80);
		acc(BIT, 1'b0, 8'h13, 8'h00);
		chk1(gotbit, 1'b1);
		acc(BIT, 1'b0, 8'h12, 8'h00);
		chk1(gotbit, 1'b0);
		acc(BIT, 1'b0, 8'h94, 8'h00);
		chk1(gotbit, 1'b1);
		acc(BIT, 1'b0, 8'h91, 8'h00);
		chk1(gotbit, 1'b0);
		acc(BIT, 1'b1, 8'hd4, 8'hff);
		chk8({6'h0, bank}, 8'h02);
		acc(DIR, 1'b1, 8'hd0, 8'h00);
	endtask
	task automatic t_stack;
		acc(STK, 1'b1, 8'h00, 8'h99, data_mem_pkg::STACK_PUSH);
		chk8(stack_ptr, 8'h08);
		acc(DIR, 1'b0, 8'h08, 8'h00);
		chk8(got, 8'h99);
		acc(STK, 1'b0, 8'h00, 8'h00, data_mem_pkg::STACK_POP);
		chk8(got, 8'h99);
		chk8(stack_ptr, 8'h07);
		acc(DIR, 1'b1, 8'h81, 8'hff);
		acc(STK, 1'b1, 8'h00, 8'h66, data_mem_pkg::STACK_PUSH);
		chk8(stack_ptr, 8'h00);
		acc(DIR, 1'b0, 8'h00, 8'h00);
		chk8(got, 8'h66);
		acc(STK, 1'b0, 8'h00, 8'h00, data_mem_pkg::STACK_POP);
		chk8(stack_ptr, 8'hff);
	endtask
	// reset again in mid-run: pointer and bank return, first push lands at 0x08
	task automatic t_rerun;
		acc(DIR, 1'b1, 8'hd0, 8'h18);
		chk8({6'h0, bank}, 8'h03);
		rst_n_i = 1'b0;
		tick();
		chk8(stack_ptr, 8'h07);
		chk8({6'h0, bank}, 8'h00);
		rst_n_i = 1'b1;
		acc(STK, 1'b1, 8'h00, 8'h3e, data_mem_pkg::STACK_PUSH);
		acc(DIR, 1'b0, 8'h08, 8'h00);
		chk8(got, 8'h3e);
	endtask
	task automatic t_external_data_space;
		xacc(1'b1, 9'h000, 8'h11);
		xacc(1'b1, 9'h100, 8'h22);
		xacc(1'b1, 9'h1ff, 8'h33);
		xacc(1'b0, 9'h000, 8'h00);
		chk8(got, 8'h11);
		xacc(1'b0, 9'h100, 8'h00);
		chk8(got, 8'h22);
		xacc(1'b0, 9'h1ff, 8'h00);
		chk8(got, 8'h33);
	endtask
	initial begin
		repeat (8) @(posedge mclk_i);
		#1 rst_n_i = 1'b1;
		t_reset();
		t_spaces();
		t_banks();
		t_bits();
		t_stack();
		t_rerun();
		t_external_data_space();
		close_out();
	end
endmodule
